// file: logic/usb_cmd_pkg.sv
package usb_cmd_pkg;
  // =====================================
  // command codes
  localparam logic [7:0] CMD_SEL_EP = 8'h00;
  localparam logic [7:0] CMD_STALL = 8'h40;
  localparam logic [7:0] CMD_BUF = 8'hf0;
  localparam logic [7:0] CMD_ACK_SETUP = 8'hf1;
  localparam logic [7:0] CMD_CLEAR = 8'hf2;
  localparam logic [7:0] CMD_INT_READ = 8'hf4;
  localparam logic [7:0] CMD_FRAME = 8'hf5;
  localparam logic [7:0] CMD_RESUME = 8'hf6;
  localparam logic [7:0] CMD_VALIDATE = 8'hfa;
  localparam logic [7:0] CMD_INT_MODE = 8'hec;
  localparam logic [7:0] CMD_VENDOR = 8'heb;
  localparam logic [7:0] CMD_PRODUCT = 8'hea;
  localparam logic [7:0] CMD_MAKER = 8'hed;
  localparam logic [7:0] CMD_DRIVE = 8'he9;
  localparam logic [3:0] GRP_SEL = 4'h0;
  localparam logic [3:0] GRP_STALL = 4'h4;
  // =====================================
  // endpoints and fields
  localparam int EP_W = 4;
  localparam int EP_N = 16;
  localparam logic [3:0] EP_LAST_DEF = 4'h5;
  localparam logic [3:0] EP_CTRL_OUT = 4'h0;
  localparam logic [3:0] EP_CTRL_IN = 4'h1;
  localparam int STALL_BIT = 0;
  localparam logic [2:0] PRIME_DEF = 3'h2;
  localparam logic [2:0] PRIME_ENH = 3'h4;
  localparam logic [1:0] PH_LEN_MSB = 2'h0;
  localparam logic [1:0] PH_LEN_LSB = 2'h1;
  localparam logic [1:0] PH_PAYLOAD = 2'h2;
  // =====================================
  // reset values
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [10:0] FRAME_RST = 11'h000;
  localparam logic [13:0] PIN_IDLE = 14'h3f00;
  // =====================================
  // timing
  localparam int RESUME_MS = 10;
  localparam int CLK_KHZ = 125000;
  localparam int RESUME_CYCLES = RESUME_MS * CLK_KHZ;
  localparam int RESUME_W = 21;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SEL, ST_STALL, ST_WBUF, ST_INTRD,
    ST_FRAME, ST_VENDOR, ST_PRODUCT, ST_MAKER, ST_DRIVE
  } cmd_state_e;
endpackage

// file: logic/usb_ep_ram.sv
`timescale 1ns/1ps
// =====================================
// endpoint payload store
module usb_ep_ram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic clk_sys_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: contents are only meaningful once a buffer is validated
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// file: logic/usb_cmd_engine.sv
`timescale 1ns/1ps
module usb_cmd_engine #(
  parameter int MAX_PKT = 64,
  parameter int RESUME_CYCLES = usb_cmd_pkg::RESUME_CYCLES,
  parameter logic [15:0] VENDOR_CODE = 16'h5a01, // arbitrary value
  parameter logic [15:0] PRODUCT_CODE = 16'h00c3, // arbitrary value
  parameter logic [7:0] MAKER_CODE = 8'h3c // arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic a0_i,
  input wire logic dma_ack_n_i,
  input wire logic dma_transfer_end_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic enhanced_mode_i,
  input wire logic suspended_i,
  input wire logic setup_rx_i,
  input wire logic sof_valid_i,
  input wire logic [10:0] sof_frame_i,
  input wire logic [31:0] int_reg_i,
  input wire logic [usb_cmd_pkg::EP_N-1:0] in_sent_i,
  input wire logic [usb_cmd_pkg::EP_W-1:0] sie_ep_i,
  input wire logic [$clog2(MAX_PKT)-1:0] sie_addr_i,
  output logic [7:0] sie_data_o,
  output logic [$clog2(MAX_PKT):0] in_len_o,
  output logic [usb_cmd_pkg::EP_N-1:0] in_full_o,
  output logic [usb_cmd_pkg::EP_N-1:0] stall_o,
  output logic [usb_cmd_pkg::EP_N-1:0] toggle_reset_o,
  output logic [usb_cmd_pkg::EP_N-1:0] out_release_o,
  output logic resume_o,
  output logic [7:0] drive_strength_o
);
  import usb_cmd_pkg::*;

  localparam int PW = $clog2(MAX_PKT);
  localparam logic [PW:0] PKT_LAST = (PW+1)'(MAX_PKT - 1);
  // full-size pointer value needs the extra bit, a 6-bit cut would read as zero
  localparam logic [PW:0] PKT_FULL = (PW+1)'(MAX_PKT);
  localparam logic [RESUME_W-1:0] RESUME_LOAD = RESUME_W'(RESUME_CYCLES);

  function automatic logic ep_ok(input logic [3:0] ep, input logic enh);
    ep_ok = enh || (ep <= EP_LAST_DEF);
  endfunction

  function automatic logic [EP_N-1:0] onehot(input logic [EP_W-1:0] ep);
    onehot = EP_N'(1) << ep;
  endfunction

  // =====================================
  // pin synchronisers
  logic [13:0] pin_s1;
  logic [13:0] pin_s2;
  logic [13:0] pin_s3;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
    end
    else
    begin
      pin_s1 <= {cs_n_i, wr_n_i, rd_n_i, a0_i, dma_ack_n_i, dma_transfer_end_n_i, data_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // data taken from the older stage, still inside the strobe low time
  logic [7:0] din;
  logic sel_cs;
  logic sel_dma;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic cmd_wr;
  logic dat_wr;
  logic dma_wr;
  logic rd_start;
  logic rd_done;
  logic eot_fall;
  assign din = pin_s3[7:0];
  assign sel_cs = !pin_s2[13];
  assign sel_dma = !pin_s2[9] && pin_s2[13];
  assign wr_rise = pin_s2[12] && !pin_s3[12];
  assign rd_fall = !pin_s2[11] && pin_s3[11];
  assign rd_rise = pin_s2[11] && !pin_s3[11];
  assign cmd_wr = sel_cs && wr_rise && pin_s3[10];
  assign dat_wr = sel_cs && wr_rise && !pin_s3[10];
  assign dma_wr = sel_dma && wr_rise;
  assign rd_start = sel_cs && rd_fall && !pin_s2[10];
  assign rd_done = sel_cs && rd_rise && !pin_s3[10];
  assign eot_fall = !pin_s2[8] && pin_s3[8];

  // =====================================
  // command decode
  cmd_state_e state;
  logic [EP_W-1:0] sel_ep;
  logic [EP_W-1:0] stall_ep;
  logic [1:0] phase;
  logic [PW:0] wptr;
  logic [PW:0] dptr;
  logic [1:0] rd_idx;
  logic [2:0] int_cnt;
  logic primed;
  logic buf_held;
  logic prime4;
  logic [1:0] lock;
  logic locked;
  logic buf_byte;
  logic stall_wr;
  logic dma_val;
  logic cmd_val;
  logic cmd_clr;
  logic [2:0] prime_cnt;
  logic [EP_N-1:0] next_in_full;
  logic [7:0] rd_byte;
  logic [10:0] frame;
  logic [RESUME_W-1:0] resume_cnt;
  logic [PW:0] in_len [0:EP_N-1];

  // a setup in the same cycle already blocks, so a validate command cannot undo the flush
  assign locked = (sel_ep == EP_CTRL_OUT || sel_ep == EP_CTRL_IN) &&
                  (lock[sel_ep[0]] || setup_rx_i);
  assign cmd_val = cmd_wr && din == CMD_VALIDATE && !locked;
  assign cmd_clr = cmd_wr && din == CMD_CLEAR && !locked;
  assign stall_wr = dat_wr && state == ST_STALL;
  assign prime_cnt = prime4 ? PRIME_ENH : PRIME_DEF;
  // held buffer access continues only once the interrupt read is primed
  assign buf_byte = dat_wr && (state == ST_WBUF ||
                    (state == ST_INTRD && primed && buf_held));
  // dma payload needs no length bytes; auto validate on size or end
  assign dma_val = (dma_wr && dptr == PKT_LAST) ||
                   (eot_fall && dptr != '0);

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state <= ST_IDLE;
      sel_ep <= EP_CTRL_OUT;
      stall_ep <= EP_CTRL_OUT;
      buf_held <= 1'b0;
      prime4 <= 1'b0;
    end
    else if (cmd_wr)
    begin
      buf_held <= (din == CMD_INT_READ) ? (buf_held || state == ST_WBUF) : (din == CMD_BUF);
      state <= ST_IDLE;
      if (din[7:4] == GRP_SEL && ep_ok(din[3:0], enhanced_mode_i))
      begin
        sel_ep <= din[3:0];
        state <= ST_SEL;
      end
      else if (din[7:4] == GRP_STALL && ep_ok(din[3:0], enhanced_mode_i))
      begin
        stall_ep <= din[3:0];
        state <= ST_STALL;
      end
      else
      begin
        case (din)
          CMD_BUF: state <= ST_WBUF;
          CMD_INT_READ: state <= ST_INTRD;
          CMD_FRAME: state <= ST_FRAME;
          CMD_DRIVE: state <= ST_DRIVE;
          CMD_VENDOR: state <= enhanced_mode_i ? ST_VENDOR : ST_IDLE;
          CMD_PRODUCT: state <= enhanced_mode_i ? ST_PRODUCT : ST_IDLE;
          CMD_MAKER: state <= enhanced_mode_i ? ST_MAKER : ST_IDLE;
          CMD_INT_MODE: prime4 <= prime4 || enhanced_mode_i;
          default: state <= ST_IDLE;
        endcase
      end
    end
    else if (buf_byte)
    begin
      state <= ST_WBUF;
    end
  end

  // =====================================
  // buffer write path
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      phase <= PH_LEN_MSB;
      wptr <= '0;
    end
    else if (cmd_wr && din == CMD_BUF)
    begin
      phase <= PH_LEN_MSB;
      wptr <= '0;
    end
    else if (buf_byte)
    begin
      // length bytes skipped; msb is zero by default and unused here
      case (phase)
        PH_LEN_MSB: phase <= PH_LEN_LSB;
        PH_LEN_LSB: phase <= PH_PAYLOAD;
        default: wptr <= (wptr == PKT_FULL) ? wptr : wptr + 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || dma_val)
    begin
      dptr <= '0;
    end
    else if (dma_wr)
    begin
      dptr <= dptr + 1'b1;
    end
  end

  logic mem_we;
  logic [EP_W+PW-1:0] mem_addr;
  assign mem_we = (buf_byte && phase == PH_PAYLOAD && wptr != PKT_FULL) || dma_wr;
  assign mem_addr = dma_wr ? {sel_ep, dptr[PW-1:0]} : {sel_ep, wptr[PW-1:0]};

  usb_ep_ram #(
    .AW(EP_W + PW),
    .DW(8)
  ) u_ram (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_addr),
    .wr_data_i(din),
    .rd_addr_i({sie_ep_i, sie_addr_i}),
    .rd_data_o(sie_data_o)
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < EP_N; i++)
      begin
        in_len[i] <= '0;
      end
    end
    else if (mem_we)
    begin
      in_len[sel_ep] <= dma_wr ? dptr + 1'b1 : wptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    in_len_o <= in_len[sie_ep_i];
  end

  // =====================================
  // buffer flags, stall, setup lock
  always_comb
  begin
    next_in_full = in_full_o & ~in_sent_i;
    if (stall_wr && !din[STALL_BIT])
    begin
      next_in_full = next_in_full & ~onehot(stall_ep);
    end
    if (setup_rx_i)
    begin
      next_in_full[EP_CTRL_IN] = 1'b0;
    end
    // a validate in the same cycle as a send wins
    if (cmd_val || dma_val)
    begin
      next_in_full = next_in_full | onehot(sel_ep);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      in_full_o <= '0;
      out_release_o <= '0;
      toggle_reset_o <= '0;
    end
    else
    begin
      in_full_o <= next_in_full;
      out_release_o <= cmd_clr ? onehot(sel_ep) : '0;
      toggle_reset_o <= (stall_wr && !din[STALL_BIT]) ? onehot(stall_ep) : '0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      stall_o <= '0;
    end
    else
    begin
      if (stall_wr)
      begin
        stall_o[stall_ep] <= din[STALL_BIT];
      end
      if (setup_rx_i)
      begin
        stall_o[EP_CTRL_OUT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      lock <= 2'b00;
    end
    else if (setup_rx_i)
    begin
      lock <= 2'b11;
    end
    else if (cmd_wr && din == CMD_ACK_SETUP && sel_ep[EP_W-1:1] == '0)
    begin
      lock[sel_ep[0]] <= 1'b0;
    end
  end

  // =====================================
  // general registers
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      frame <= FRAME_RST;
    end
    else if (sof_valid_i)
    begin
      frame <= sof_frame_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      drive_strength_o <= DRIVE_RST;
    end
    else if (dat_wr && state == ST_DRIVE)
    begin
      drive_strength_o <= din;
    end
  end

  // only honoured while suspended; the clock must already run
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      resume_cnt <= '0;
    end
    else if (cmd_wr && din == CMD_RESUME && suspended_i && resume_cnt == '0)
    begin
      resume_cnt <= RESUME_LOAD;
    end
    else if (resume_cnt != '0)
    begin
      resume_cnt <= resume_cnt - 1'b1;
    end
  end
  assign resume_o = resume_cnt != '0;

  // =====================================
  // read path and priming
  always_comb
  begin
    case (state)
      ST_SEL: rd_byte = {6'h00, stall_o[sel_ep], in_full_o[sel_ep]};
      ST_FRAME: rd_byte = rd_idx == 2'h0 ? frame[7:0] : {5'h00, frame[10:8]};
      ST_VENDOR: rd_byte = rd_idx == 2'h0 ? VENDOR_CODE[7:0] : VENDOR_CODE[15:8];
      ST_PRODUCT: rd_byte = rd_idx == 2'h0 ? PRODUCT_CODE[7:0] : PRODUCT_CODE[15:8];
      ST_MAKER: rd_byte = MAKER_CODE;
      ST_INTRD: rd_byte = int_reg_i[8*int_cnt[1:0] +: 8];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      rd_idx <= 2'h0;
      int_cnt <= 3'h0;
      primed <= 1'b0;
    end
    else
    begin
      data_oe_o <= sel_cs && !pin_s2[11] && !pin_s2[10];
      if (rd_start)
      begin
        data_o <= rd_byte;
      end
      if (cmd_wr)
      begin
        rd_idx <= 2'h0;
        int_cnt <= 3'h0;
        primed <= 1'b0;
      end
      else if (rd_done)
      begin
        rd_idx <= rd_idx + 1'b1;
        if (state == ST_INTRD && int_cnt != prime_cnt)
        begin
          int_cnt <= int_cnt + 1'b1;
          primed <= (int_cnt + 1'b1) == prime_cnt;
        end
      end
    end
  end

  // =====================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  logic [RESUME_W-1:0] resume_seen;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || !resume_o)
    begin
      resume_seen <= '0;
    end
    else
    begin
      resume_seen <= resume_seen + 1'b1;
    end
  end

  sequence s_stall_zero;
    stall_wr && !din[STALL_BIT];
  endsequence
  sequence s_locked_ack;
    lock[0] && cmd_wr && din == CMD_ACK_SETUP && sel_ep == EP_CTRL_OUT && !setup_rx_i;
  endsequence

  a_setup_flush: assert property (setup_rx_i && !dma_val |=> !in_full_o[EP_CTRL_IN] && lock == 2'b11)
    else $error("setup did not flush or lock control endpoint");
  a_setup_unstall: assert property (setup_rx_i |=> !stall_o[EP_CTRL_OUT])
    else $error("setup left control out stalled");
  a_clear_blocked: assert property (cmd_wr && din == CMD_CLEAR && locked |=> out_release_o == '0)
    else $error("clear acted while locked");
  a_clear_release: assert property (cmd_clr |=> out_release_o == onehot($past(sel_ep)))
    else $error("clear did not release buffer");
  a_validate_full: assert property (cmd_val |=> in_full_o[$past(sel_ep)])
    else $error("validate did not set full");
  a_stall_reinit: assert property (s_stall_zero |=> toggle_reset_o == onehot($past(stall_ep)) ##1 toggle_reset_o == '0)
    else $error("stall clear did not reinitialise once");
  a_ack_unlock: assert property (s_locked_ack |=> !lock[0])
    else $error("setup acknowledge did not unlock");
  a_dma_auto: assert property (dma_wr && dptr == PKT_LAST |=> in_full_o[$past(sel_ep)] && dptr == '0)
    else $error("dma did not validate at max packet");
  a_frame_latch: assert property (sof_valid_i |=> frame == $past(sof_frame_i))
    else $error("frame number not captured");
  a_resume_len: assert property ($fell(resume_o) |-> $past(resume_seen) == RESUME_LOAD - 1'b1)
    else $error("resume length wrong");
  a_prime_count: assert property (rd_done && state == ST_INTRD && !cmd_wr && int_cnt == prime_cnt - 1'b1 |=> primed)
    else $error("priming not reached");
  a_drive_store: assert property (dat_wr && state == ST_DRIVE |=> drive_strength_o == $past(din))
    else $error("drive strength not stored");
endmodule

// file: verification/usb_mcu_model.sv
`timescale 1ns/1ps
// =====
// microcontroller on the parallel bus
module usb_mcu_model (
  input wire logic clk_sys_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic a0_o,
  output logic dma_ack_n_o,
  output logic dma_end_n_o,
  output logic [7:0] data_o,
  input wire logic [7:0] rdata_i
);
  import usb_cmd_pkg::*;
  initial
  begin
    {cs_n_o, wr_n_o, rd_n_o, a0_o, dma_ack_n_o, dma_end_n_o} = 6'h3f;
    data_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // strobes held three clocks each way: the pin syncs take two
  task automatic put(input logic cmd_sel, input logic dma_sel, input logic [7:0] b);
    a0_o = cmd_sel;
    data_o = b;
    cs_n_o = dma_sel;
    dma_ack_n_o = ~dma_sel;
    wr_n_o = 1'b0;
    tick(3);
    wr_n_o = 1'b1;
    tick(3);
    cs_n_o = 1'b1;
    dma_ack_n_o = 1'b1;
    data_o = ~b; // released bus, no stale byte
    tick(1);
  endtask
  task automatic cmd(input logic [7:0] b);
    put(1'b1, 1'b0, b);
  endtask
  task automatic wr(input logic [7:0] b);
    put(1'b0, 1'b0, b);
  endtask
  task automatic dma(input logic [7:0] b);
    put(1'b0, 1'b1, b);
  endtask
  task automatic get(output logic [7:0] b);
    a0_o = 1'b0;
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    tick(4);
    b = rdata_i;
    rd_n_o = 1'b1;
    tick(3);
    cs_n_o = 1'b1;
    tick(1);
  endtask
  task automatic dma_end();
    dma_end_n_o = 1'b0;
    tick(3);
    dma_end_n_o = 1'b1;
    tick(3);
  endtask
  // length bytes are header only, the device counts payload itself
  task automatic fill(input logic [7:0] n, input logic [7:0] base);
    cmd(CMD_BUF);
    wr(8'h00);
    wr(n);
    for (int i = 0; i < n; i++)
      wr(base + i[7:0]);
    cmd(CMD_VALIDATE);
  endtask
  task automatic drain();
    cmd(CMD_CLEAR);
  endtask
  task automatic ack_setup();
    cmd({4'h0, EP_CTRL_OUT});
    cmd(CMD_ACK_SETUP);
    cmd({4'h0, EP_CTRL_IN});
    cmd(CMD_ACK_SETUP);
  endtask
endmodule

// file: verification/usb_endpoint_command_set_bench.sv
`timescale 1ns/1ps
module usb_endpoint_command_set_bench;
  import usb_cmd_pkg::*;
  localparam int RES = 20;
  localparam int PKT = 64;
  localparam int LIMIT = 30000;
  localparam logic [15:0] VEND = 16'h2b71; // arbitrary value
  localparam logic [15:0] PROD = 16'h0e5d; // arbitrary value
  localparam logic [7:0] MAKER = 8'h96; // arbitrary value
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic cs_n, wr_n, rd_n, a0, dack_n, dend_n, oe, resume;
  logic enh = 1'b0, susp = 1'b0, setup = 1'b0, sof = 1'b0, oe_seen = 1'b0;
  logic [7:0] din, dout, sie_data, drive;
  logic [10:0] frame = 11'h000;
  logic [31:0] intr = 32'hc4a5_3e19;
  logic [15:0] sent = 16'h0000, tr_seen = 16'h0000, rel_seen = 16'h0000;
  logic [15:0] full, stall, tr, rel;
  logic [3:0] sie_ep = 4'h0;
  logic [5:0] sie_addr = 6'h00;
  logic [6:0] len;
  int n_fail = 0, n_tests = 0, cyc = 0, res_cnt = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  usb_mcu_model usb_mcu_model_i (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .a0_o(a0), .dma_ack_n_o(dack_n), .dma_end_n_o(dend_n),
    .data_o(din), .rdata_i(dout));
  usb_cmd_engine #(.MAX_PKT(PKT), .RESUME_CYCLES(RES), .VENDOR_CODE(VEND),
    .PRODUCT_CODE(PROD), .MAKER_CODE(MAKER)) usb_cmd_engine_i (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .a0_i(a0),
    .dma_ack_n_i(dack_n), .dma_transfer_end_n_i(dend_n), .data_i(din), .data_o(dout),
    .data_oe_o(oe), .enhanced_mode_i(enh), .suspended_i(susp), .setup_rx_i(setup),
    .sof_valid_i(sof), .sof_frame_i(frame), .int_reg_i(intr), .in_sent_i(sent),
    .sie_ep_i(sie_ep), .sie_addr_i(sie_addr), .sie_data_o(sie_data), .in_len_o(len),
    .in_full_o(full), .stall_o(stall), .toggle_reset_o(tr), .out_release_o(rel),
    .resume_o(resume), .drive_strength_o(drive));
  // =====
  // monitors and run control
  // one-cycle pulses are caught sticky, so a late look cannot miss them
  always @(posedge clk_sys_i)
  begin
    tr_seen <= tr_seen | tr;
    rel_seen <= rel_seen | rel;
    oe_seen <= oe_seen | oe;
    res_cnt <= res_cnt + int'(resume);
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask
  task automatic tick(input int n);
    usb_mcu_model_i.tick(n);
  endtask
  task automatic cmd(input logic [7:0] b);
    usb_mcu_model_i.cmd(b);
  endtask
  task automatic wr(input logic [7:0] b);
    usb_mcu_model_i.wr(b);
  endtask
  task automatic rd_chk(input logic [7:0] exp);
    logic [7:0] b;
    oe_seen = 1'b0;
    usb_mcu_model_i.get(b);
    chk(b, exp);
    chk({oe_seen, oe}, 2'h2);
  endtask
  task automatic pay_chk(input logic [3:0] ep, input logic [7:0] n, input logic [7:0] base);
    sie_ep = ep;
    for (int i = 0; i < n; i++)
    begin
      sie_addr = i[5:0];
      tick(2);
      chk(sie_data, base + i[7:0]);
    end
    chk(len, n);
  endtask
  // =====
  // scenarios
  task automatic t_reset();
    chk(drive, DRIVE_RST);
    chk(stall | full, 16'h0000);
    cmd(CMD_FRAME);
    rd_chk(8'h00);
    rd_chk(8'h00);
  endtask
  task automatic t_drive(input logic [7:0] v);
    cmd(CMD_DRIVE);
    wr(v);
    chk(drive, v);
  endtask
  task automatic t_frame();
    frame = 11'h5a3;
    sof = 1'b1;
    tick(1);
    sof = 1'b0;
    cmd(CMD_FRAME);
    rd_chk(8'ha3);
    rd_chk(8'h05);
  endtask
  task automatic t_buf();
    cmd(8'h02);
    usb_mcu_model_i.fill(8'h03, 8'h10);
    chk(full[2], 1'b1);
    pay_chk(4'h2, 8'h03, 8'h10);
    sent = 16'h0004;
    tick(1);
    sent = 16'h0000;
    tick(1);
    chk(full[2], 1'b0);
    rel_seen = 16'h0000;
    usb_mcu_model_i.drain();
    chk(rel_seen, 16'h0004);
  endtask
  task automatic t_stall();
    cmd(8'h05);
    usb_mcu_model_i.fill(8'h02, 8'h20);
    cmd(8'h45);
    wr(8'h01);
    chk(stall[5], 1'b1);
    cmd(8'h05);
    rd_chk(8'h03);
    tr_seen = 16'h0000;
    cmd(8'h45);
    wr(8'hfe);
    chk(stall[5], 1'b0);
    chk(tr_seen, 16'h0020);
    chk(full[5], 1'b0);
    cmd(8'h46);
    wr(8'h01);
    chk(stall, 16'h0000);
    enh = 1'b1;
    cmd(8'h4f);
    wr(8'h01);
    chk(stall, 16'h8000);
    enh = 1'b0;
  endtask
  task automatic t_setup();
    cmd(CMD_STALL);
    wr(8'h01);
    cmd(8'h01);
    usb_mcu_model_i.fill(8'h01, 8'h30);
    chk({stall[0], full[1]}, 2'h3);
    setup = 1'b1;
    tick(1);
    setup = 1'b0;
    tick(2);
    chk({stall[0], full[1]}, 2'h0);
    cmd(CMD_VALIDATE);
    rel_seen = 16'h0000;
    cmd(8'h00);
    usb_mcu_model_i.drain();
    chk({rel_seen[0], full[1]}, 2'h0);
    usb_mcu_model_i.ack_setup();
    cmd(CMD_VALIDATE);
    cmd(8'h00);
    usb_mcu_model_i.drain();
    chk({rel_seen[0], full[1]}, 2'h3);
  endtask
  task automatic t_resume();
    res_cnt = 0;
    cmd(CMD_RESUME);
    tick(RES + 4);
    chk(16'(res_cnt), 16'h0000);
    // clock never stops here, so no wake step comes first
    susp = 1'b1;
    cmd(CMD_RESUME);
    tick(RES + 4);
    chk(16'(res_cnt), 16'(RES));
    susp = 1'b0;
  endtask
  task automatic t_dma();
    cmd(8'h03);
    for (int i = 0; i < PKT; i++)
      usb_mcu_model_i.dma(i[7:0]);
    chk(full[3], 1'b1);
    pay_chk(4'h3, PKT[7:0], 8'h00);
    cmd(8'h04);
    usb_mcu_model_i.dma(8'h77);
    usb_mcu_model_i.dma(8'h78);
    chk(full[4], 1'b0);
    usb_mcu_model_i.dma_end();
    chk(full[4], 1'b1);
    pay_chk(4'h4, 8'h02, 8'h77);
  endtask
  task automatic t_prime(input logic [3:0] ep, input int nrd);
    logic [7:0] b;
    cmd({4'h0, ep});
    cmd(CMD_BUF);
    wr(8'h00);
    wr(8'h02);
    wr(8'h51);
    cmd(CMD_INT_READ);
    for (int i = 0; i < nrd; i++)
    begin
      usb_mcu_model_i.get(b);
      chk(b, intr[8*i+:8]);
    end
    wr(8'h52);
    cmd(CMD_VALIDATE);
    pay_chk(ep, 8'h02, 8'h51);
  endtask
  task automatic t_ident();
    cmd(CMD_VENDOR);
    rd_chk(VEND[7:0]);
    rd_chk(VEND[15:8]);
    cmd(CMD_PRODUCT);
    rd_chk(PROD[7:0]);
    rd_chk(PROD[15:8]);
    cmd(CMD_MAKER);
    rd_chk(MAKER);
  endtask
  initial
  begin
    tick(5);
    srst_i = 1'b0;
    tick(1);
    t_reset();
    t_drive(8'h1b);
    t_drive(8'he4);
    t_frame();
    t_buf();
    t_stall();
    t_setup();
    t_resume();
    t_dma();
    t_prime(4'h2, 2);
    enh = 1'b1;
    cmd(CMD_INT_MODE);
    t_prime(4'h6, 4);
    t_ident();
    stop_test();
  end
endmodule
